// ==== dpatc_pkg.sv ====
// Purpose: shared constants for the dual peak converter transfer control
// Assumes: 40 MHz system clock
// Notes:   all times in ns, cycle counts derived here
package dpatc_pkg;
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          DATA_WIDTH       = 16;
  localparam int          FIFO_DEPTH       = 8;
  localparam int          CONV_MAX_NS      = 17000;
  localparam int          XFER_BUDGET_NS   = 30000;
  localparam int          CONV_MAX_CYCLES  = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int          XFER_MAX_CYCLES  = XFER_BUDGET_NS / CLK_PERIOD_NS;
  localparam int          START_PULSE_NS   = 100;
  localparam int          START_CYCLES     = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          REARM_PULSE_NS   = 100;
  localparam int          REARM_CYCLES     = (REARM_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          REQ_PULSE_NS     = 100;
  localparam int          REQ_CYCLES       = (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          REQ_GAP_NS       = 2000;
  localparam int          REQ_GAP_CYCLES   = (REQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TIMER_WIDTH      = 12;
  localparam logic [15:0] NO_EVENT_CODE    = 16'hFFFF;
  localparam logic [1:0]  WORD_FLIGHT_TIME = 2'h0;
  localparam logic [1:0]  WORD_PULSE       = 2'h1;
  localparam logic [1:0]  WORD_EVENT       = 2'h2;
endpackage

// ==== dpatc_fifo.sv ====
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module dpatc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  // drain side
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign wr_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign rd_valid_out = wr_ptr != rd_ptr;
  assign rd_data_out  = mem[rd_ptr[AW-1:0]];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_wr) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage has no reset, contents only matter behind valid
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end
endmodule
`default_nettype wire

// ==== dpatc_channel.sv ====
// Purpose: sequencer for one peak-capture channel and its converter
// Assumes: pin inputs already pass two flip-flops in the top module
// Notes:   one instance per channel, channels run independently
`timescale 1ns/1ps
`default_nettype none
module dpatc_channel (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // synchronised pins
  input  wire logic        peak_captured_n_in,
  input  wire logic        busy_n_in,
  input  wire logic [15:0] conv_data_in,
  // converter and detector controls
  output logic             start_out,
  output logic             rearm_out,
  // result
  output logic [15:0]      result_out,
  output logic             done_out,
  output logic             timeout_out,
  input  wire logic        consume_in
);
  typedef enum logic [4:0] {
    CH_IDLE  = 5'b00001,
    CH_START = 5'b00010,
    CH_CONV  = 5'b00100,
    CH_REARM = 5'b01000,
    CH_HOLD  = 5'b10000
  } dpatc_ch_state_type;

  dpatc_ch_state_type state;
  dpatc_ch_state_type next_state;
  logic [dpatc_pkg::TIMER_WIDTH-1:0] timer;
  logic [dpatc_pkg::TIMER_WIDTH-1:0] next_timer;
  logic        busy_n_d;
  logic [15:0] next_result;
  logic        next_timeout;
  logic        next_start;
  logic        next_rearm;
  logic        busy_rise;

  assign busy_rise = busy_n_in && !busy_n_d;

  always_comb begin
    next_state   = state;
    next_timer   = timer;
    next_result  = result_out;
    next_timeout = timeout_out;
    next_start   = 1'b0;
    next_rearm   = 1'b0;
    case (state)
      CH_IDLE: begin
        // R1 start on capture
        if (!peak_captured_n_in) begin
          next_state = CH_START;
          next_timer = '0;
          next_start = 1'b1;
        end
      end
      CH_START: begin
        next_timer = timer + 1'b1;
        next_start = 1'b1;
        if (timer == dpatc_pkg::TIMER_WIDTH'(dpatc_pkg::START_CYCLES - 1)) begin
          next_start = 1'b0;
          next_state = CH_CONV;
          next_timer = '0;
        end
      end
      CH_CONV: begin
        next_timer = timer + 1'b1;
        // R2 rearm on status rise
        if (busy_rise) begin
          next_result  = conv_data_in;
          next_timeout = 1'b0;
          next_rearm   = 1'b1;
          next_timer   = '0;
          next_state   = CH_REARM;
        // R7 conversion time bound
        end else if (timer == dpatc_pkg::TIMER_WIDTH'(dpatc_pkg::CONV_MAX_CYCLES)) begin
          next_result  = conv_data_in;
          next_timeout = 1'b1;
          next_rearm   = 1'b1;
          next_timer   = '0;
          next_state   = CH_REARM;
        end
      end
      CH_REARM: begin
        next_timer = timer + 1'b1;
        next_rearm = 1'b1;
        if (timer == dpatc_pkg::TIMER_WIDTH'(dpatc_pkg::REARM_CYCLES - 1)) begin
          next_rearm = 1'b0;
          next_state = CH_HOLD;
        end
      end
      CH_HOLD: begin
        // R8 hold until consumed
        if (consume_in) begin
          next_state = CH_IDLE;
        end
      end
      default: begin
        next_state = CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state       <= CH_IDLE;
      timer       <= '0;
      busy_n_d    <= 1'b1;
      result_out  <= 16'h0000;
      timeout_out <= 1'b0;
      start_out   <= 1'b0;
      rearm_out   <= 1'b0;
      done_out    <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      busy_n_d    <= busy_n_in;
      result_out  <= next_result;
      timeout_out <= next_timeout;
      start_out   <= next_start;
      rearm_out   <= next_rearm;
      done_out    <= (next_state == CH_HOLD);
    end
  end
endmodule
`default_nettype wire

// ==== dpatc_top.sv ====
// Purpose: two-channel peak converter control and host word transfer
// Assumes: 40 MHz SYS_CLK_IN, synchronous active-high RST_IN
// Notes:   store strobe and all converter pins are asynchronous
// How it works
// R1 - A low peak-captured level on a channel makes that channel's converter receive a start pulse.
// R2 - The rising edge of a converter's active-low status re-arms that channel's peak detector.
// R3 - Results move to the host only after the test circuit strobes a store.
// R4 - The test circuit's 16-bit event code, all ones for no event, is sent along with the results.
// R5 - Each word sent to the host begins with one request pulse.
// R6 - The three words of one store are sent within about 30 microseconds.
// R7 - Each channel yields a 16-bit result and a conversion is given at most 17 microseconds.
// R8 - Channels run independently, a store waits for both, and words go flight time, pulse height, event code.
`timescale 1ns/1ps
`default_nettype none
module dpatc_top (
  // clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  // channel a, flight time
  input  wire logic        PEAK_CAPTURED_A_N_IN,
  input  wire logic        CONV_BUSY_A_N_IN,
  input  wire logic [15:0] CONV_DATA_A_IN,
  output logic             CONV_START_A_OUT,
  output logic             PEAK_REARM_A_OUT,
  // channel b, pulse height
  input  wire logic        PEAK_CAPTURED_B_N_IN,
  input  wire logic        CONV_BUSY_B_N_IN,
  input  wire logic [15:0] CONV_DATA_B_IN,
  output logic             CONV_START_B_OUT,
  output logic             PEAK_REARM_B_OUT,
  // user test circuit
  input  wire logic        STORE_IN,
  input  wire logic [15:0] EVENT_CODE_IN,
  // host dma board
  output logic [15:0]      HOST_DATA_OUT,
  output logic             HOST_REQ_OUT,
  output logic             CONV_TIMEOUT_OUT,
  output logic             XFER_OVERRUN_OUT
);
  typedef enum logic [3:0] {
    XF_IDLE = 4'b0001,
    XF_LOAD = 4'b0010,
    XF_REQ  = 4'b0100,
    XF_GAP  = 4'b1000
  } dpatc_xf_state_type;

  // two-flop synchronisers, first stage read only by second
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [15:0] data_a_s1;
  logic [15:0] data_a_s2;
  logic [15:0] data_b_s1;
  logic [15:0] data_b_s2;
  logic [15:0] code_s1;
  logic [15:0] code_s2;
  logic        store_d;
  logic        store_rise;
  logic        store_pend;
  logic        next_store_pend;

  logic [15:0] result_a;
  logic [15:0] result_b;
  logic        done_a;
  logic        done_b;
  logic        tmo_a;
  logic        tmo_b;
  logic        consume;
  logic        start_a;
  logic        start_b;
  logic        rearm_a;
  logic        rearm_b;

  logic [1:0]  load_idx;
  logic [1:0]  next_load_idx;
  logic        loading;
  logic        next_loading;
  logic [15:0] code_latched;
  logic [15:0] next_code_latched;
  logic [15:0] fifo_wr_data;
  logic        fifo_wr_valid;
  logic        fifo_wr_ready;
  logic [15:0] fifo_rd_data;
  logic        fifo_rd_valid;
  logic        fifo_rd_ready;

  dpatc_xf_state_type xf_state;
  dpatc_xf_state_type next_xf_state;
  logic [dpatc_pkg::TIMER_WIDTH-1:0] xf_timer;
  logic [dpatc_pkg::TIMER_WIDTH-1:0] next_xf_timer;
  logic [dpatc_pkg::TIMER_WIDTH-1:0] budget;
  logic [dpatc_pkg::TIMER_WIDTH-1:0] next_budget;
  logic        budget_run;
  logic        next_budget_run;
  logic        overrun;
  logic        next_overrun;
  logic [15:0] next_host_data;
  logic        next_host_req;

  function automatic logic [15:0] pick_word(input logic [1:0] idx, input logic [15:0] a,
                                            input logic [15:0] b, input logic [15:0] c);
    case (idx)
      dpatc_pkg::WORD_FLIGHT_TIME: pick_word = a;
      dpatc_pkg::WORD_PULSE:       pick_word = b;
      default:                     pick_word = c;
    endcase
  endfunction

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sync1     <= 4'hF;
      sync2     <= 4'hF;
      data_a_s1 <= 16'h0000;
      data_a_s2 <= 16'h0000;
      data_b_s1 <= 16'h0000;
      data_b_s2 <= 16'h0000;
      code_s1   <= dpatc_pkg::NO_EVENT_CODE;
      code_s2   <= dpatc_pkg::NO_EVENT_CODE;
      store_d   <= 1'b0;
    end else begin
      sync1     <= {PEAK_CAPTURED_A_N_IN, CONV_BUSY_A_N_IN, PEAK_CAPTURED_B_N_IN, CONV_BUSY_B_N_IN};
      sync2     <= sync1;
      data_a_s1 <= CONV_DATA_A_IN;
      data_a_s2 <= data_a_s1;
      data_b_s1 <= CONV_DATA_B_IN;
      data_b_s2 <= data_b_s1;
      code_s1   <= EVENT_CODE_IN;
      code_s2   <= code_s1;
      store_d   <= STORE_IN;
    end
  end

  // store is a level into one sync stage pair via its own flops
  logic store_s1;
  logic store_s2;
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      store_s1 <= 1'b0;
      store_s2 <= 1'b0;
    end else begin
      store_s1 <= store_d;
      store_s2 <= store_s1;
    end
  end
  assign store_rise = store_s1 && !store_s2;

  // R8 independent channels
  dpatc_channel u_chan_a (
    .clk_in             (SYS_CLK_IN),
    .rst_in             (RST_IN),
    .peak_captured_n_in (sync2[3]),
    .busy_n_in          (sync2[2]),
    .conv_data_in       (data_a_s2),
    .start_out          (start_a),
    .rearm_out          (rearm_a),
    .result_out         (result_a),
    .done_out           (done_a),
    .timeout_out        (tmo_a),
    .consume_in         (consume)
  );

  dpatc_channel u_chan_b (
    .clk_in             (SYS_CLK_IN),
    .rst_in             (RST_IN),
    .peak_captured_n_in (sync2[1]),
    .busy_n_in          (sync2[0]),
    .conv_data_in       (data_b_s2),
    .start_out          (start_b),
    .rearm_out          (rearm_b),
    .result_out         (result_b),
    .done_out           (done_b),
    .timeout_out        (tmo_b),
    .consume_in         (consume)
  );

  // load side: three words into the fifo per served store
  always_comb begin
    next_store_pend   = store_pend;
    next_loading      = loading;
    next_load_idx     = load_idx;
    next_code_latched = code_latched;
    consume           = 1'b0;
    // R3 store gates transfer, set wins over the serve
    if (store_rise) begin
      next_store_pend   = 1'b1;
      // R4 event code captured with store
      next_code_latched = code_s2;
    end
    // R8 wait for both results
    if (!loading && store_pend && done_a && done_b) begin
      next_loading  = 1'b1;
      next_load_idx = dpatc_pkg::WORD_FLIGHT_TIME;
      if (!store_rise) begin
        next_store_pend = 1'b0;
      end
    end
    if (loading && fifo_wr_ready) begin
      if (load_idx == dpatc_pkg::WORD_EVENT) begin
        next_loading = 1'b0;
        consume      = 1'b1;
      end else begin
        next_load_idx = load_idx + 2'h1;
      end
    end
  end
  assign fifo_wr_valid = loading;
  // R8 word order
  assign fifo_wr_data  = pick_word(load_idx, result_a, result_b, code_latched);

  dpatc_fifo #(
    .WIDTH (dpatc_pkg::DATA_WIDTH),
    .DEPTH (dpatc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (SYS_CLK_IN),
    .rst_in       (RST_IN),
    .wr_data_in   (fifo_wr_data),
    .wr_valid_in  (fifo_wr_valid),
    .wr_ready_out (fifo_wr_ready),
    .rd_data_out  (fifo_rd_data),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_ready)
  );

  // drain side: one request pulse per word, paced by the gap
  assign fifo_rd_ready = (xf_state == XF_IDLE);

  always_comb begin
    next_xf_state   = xf_state;
    next_xf_timer   = xf_timer;
    next_host_data  = HOST_DATA_OUT;
    next_host_req   = 1'b0;
    next_budget     = budget;
    next_budget_run = budget_run;
    next_overrun    = overrun;
    // R6 budget from first word of a store
    if (loading && load_idx == dpatc_pkg::WORD_FLIGHT_TIME && fifo_wr_ready) begin
      next_budget_run = 1'b1;
      next_budget     = '0;
    end else if (budget_run) begin
      next_budget = budget + 1'b1;
      if (budget == dpatc_pkg::TIMER_WIDTH'(dpatc_pkg::XFER_MAX_CYCLES)) begin
        next_overrun    = 1'b1;
        next_budget_run = 1'b0;
      end
    end
    case (xf_state)
      XF_IDLE: begin
        if (fifo_rd_valid) begin
          next_host_data = fifo_rd_data;
          next_xf_state  = XF_LOAD;
        end
      end
      XF_LOAD: begin
        // data settles one cycle before the request
        next_host_req = 1'b1;
        next_xf_timer = '0;
        next_xf_state = XF_REQ;
      end
      XF_REQ: begin
        // R5 request pulse per word
        next_xf_timer = xf_timer + 1'b1;
        next_host_req = 1'b1;
        if (xf_timer == dpatc_pkg::TIMER_WIDTH'(dpatc_pkg::REQ_CYCLES - 1)) begin
          next_host_req = 1'b0;
          next_xf_timer = '0;
          next_xf_state = XF_GAP;
        end
      end
      XF_GAP: begin
        next_xf_timer = xf_timer + 1'b1;
        if (xf_timer == dpatc_pkg::TIMER_WIDTH'(dpatc_pkg::REQ_GAP_CYCLES - 1)) begin
          next_xf_state = XF_IDLE;
          if (!fifo_rd_valid && !loading) begin
            next_budget_run = 1'b0;
          end
        end
      end
      default: begin
        next_xf_state = XF_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      store_pend       <= 1'b0;
      loading          <= 1'b0;
      load_idx         <= dpatc_pkg::WORD_FLIGHT_TIME;
      code_latched     <= dpatc_pkg::NO_EVENT_CODE;
      xf_state         <= XF_IDLE;
      xf_timer         <= '0;
      budget           <= '0;
      budget_run       <= 1'b0;
      overrun          <= 1'b0;
      HOST_DATA_OUT    <= 16'h0000;
      HOST_REQ_OUT     <= 1'b0;
      CONV_START_A_OUT <= 1'b0;
      CONV_START_B_OUT <= 1'b0;
      PEAK_REARM_A_OUT <= 1'b0;
      PEAK_REARM_B_OUT <= 1'b0;
      CONV_TIMEOUT_OUT <= 1'b0;
      XFER_OVERRUN_OUT <= 1'b0;
    end else begin
      store_pend       <= next_store_pend;
      loading          <= next_loading;
      load_idx         <= next_load_idx;
      code_latched     <= next_code_latched;
      xf_state         <= next_xf_state;
      xf_timer         <= next_xf_timer;
      budget           <= next_budget;
      budget_run       <= next_budget_run;
      overrun          <= next_overrun;
      HOST_DATA_OUT    <= next_host_data;
      HOST_REQ_OUT     <= next_host_req;
      CONV_START_A_OUT <= start_a;
      CONV_START_B_OUT <= start_b;
      PEAK_REARM_A_OUT <= rearm_a;
      PEAK_REARM_B_OUT <= rearm_b;
      CONV_TIMEOUT_OUT <= tmo_a || tmo_b;
      XFER_OVERRUN_OUT <= next_overrun;
    end
  end
endmodule
`default_nettype wire

// ==== dpatc_top_props.sv ====
// Purpose: concurrent checks on the transfer control top ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every dpatc_top instance
`timescale 1ns/1ps
`default_nettype none
module dpatc_top_props (
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_IN,
  input wire logic        PEAK_CAPTURED_A_N_IN,
  input wire logic        CONV_BUSY_A_N_IN,
  input wire logic [15:0] CONV_DATA_A_IN,
  input wire logic        CONV_START_A_OUT,
  input wire logic        PEAK_REARM_A_OUT,
  input wire logic        PEAK_CAPTURED_B_N_IN,
  input wire logic        CONV_BUSY_B_N_IN,
  input wire logic [15:0] CONV_DATA_B_IN,
  input wire logic        CONV_START_B_OUT,
  input wire logic        PEAK_REARM_B_OUT,
  input wire logic        STORE_IN,
  input wire logic [15:0] EVENT_CODE_IN,
  input wire logic [15:0] HOST_DATA_OUT,
  input wire logic        HOST_REQ_OUT,
  input wire logic        CONV_TIMEOUT_OUT,
  input wire logic        XFER_OVERRUN_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  a_start_cause_a: assert property ($rose(CONV_START_A_OUT) |-> !$past(PEAK_CAPTURED_A_N_IN, 3))
    else $error("start a without captured peak");
  a_start_cause_b: assert property ($rose(CONV_START_B_OUT) |-> !$past(PEAK_CAPTURED_B_N_IN, 3))
    else $error("start b without captured peak");
  a_start_width: assert property ($rose(CONV_START_A_OUT) |-> CONV_START_A_OUT[*4] ##1 !CONV_START_A_OUT)
    else $error("start a pulse width wrong");
  a_rearm_after_a: assert property ($rose(CONV_BUSY_A_N_IN) |-> ##[1:8] PEAK_REARM_A_OUT)
    else $error("no rearm a after conversion end");
  a_rearm_after_b: assert property ($rose(CONV_BUSY_B_N_IN) |-> ##[1:8] PEAK_REARM_B_OUT)
    else $error("no rearm b after conversion end");
  a_rearm_width: assert property ($rose(PEAK_REARM_B_OUT) |-> PEAK_REARM_B_OUT[*4] ##1 !PEAK_REARM_B_OUT)
    else $error("rearm b pulse width wrong");
  a_req_width: assert property ($rose(HOST_REQ_OUT) |-> HOST_REQ_OUT[*4] ##1 !HOST_REQ_OUT)
    else $error("request pulse width wrong");
  a_word_held: assert property (HOST_REQ_OUT |-> $stable(HOST_DATA_OUT))
    else $error("host word moved during request");
  a_req_gap: assert property ($fell(HOST_REQ_OUT) |-> !HOST_REQ_OUT[*8])
    else $error("requests too close");
  a_budget_kept: assert property (!XFER_OVERRUN_OUT)
    else $error("transfer overran its budget");
endmodule
bind dpatc_top dpatc_top_props u_props (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
  .PEAK_CAPTURED_A_N_IN(PEAK_CAPTURED_A_N_IN), .CONV_BUSY_A_N_IN(CONV_BUSY_A_N_IN),
  .CONV_DATA_A_IN(CONV_DATA_A_IN), .CONV_START_A_OUT(CONV_START_A_OUT), .PEAK_REARM_A_OUT(PEAK_REARM_A_OUT),
  .PEAK_CAPTURED_B_N_IN(PEAK_CAPTURED_B_N_IN), .CONV_BUSY_B_N_IN(CONV_BUSY_B_N_IN),
  .CONV_DATA_B_IN(CONV_DATA_B_IN), .CONV_START_B_OUT(CONV_START_B_OUT), .PEAK_REARM_B_OUT(PEAK_REARM_B_OUT),
  .STORE_IN(STORE_IN), .EVENT_CODE_IN(EVENT_CODE_IN), .HOST_DATA_OUT(HOST_DATA_OUT),
  .HOST_REQ_OUT(HOST_REQ_OUT), .CONV_TIMEOUT_OUT(CONV_TIMEOUT_OUT), .XFER_OVERRUN_OUT(XFER_OVERRUN_OUT)
);
`default_nettype wire

// ==== dpatc_conv_model.sv ====
// Purpose: behavioural peak detector and converter for one channel
// Assumes: bench pulses hit_in for one cycle per particle
// Notes:   data toggles while converting, so a premature latch shows
`timescale 1ns/1ps
`default_nettype none
module dpatc_conv_model (
  input  wire logic        clk_in,
  input  wire logic        hit_in,
  input  wire logic        start_in,
  input  wire logic        rearm_in,
  input  wire logic [15:0] value_in,
  input  wire logic [15:0] conv_cycles_in,
  output logic             peak_n_out,
  output logic             busy_n_out,
  output logic [15:0]      data_out
);
  logic [15:0] cnt;
  initial begin
    peak_n_out = 1'b1;
    busy_n_out = 1'b1;
    data_out   = 16'h0000;
    cnt        = 16'h0000;
  end
  always @(posedge clk_in) begin
    if (hit_in)
      peak_n_out <= 1'b0;
    else if (rearm_in)
      peak_n_out <= 1'b1;
    // 16-bit result after a bounded conversion
    if (start_in && busy_n_out && cnt == 16'h0000) begin
      busy_n_out <= 1'b0;
      cnt        <= conv_cycles_in;
    end else if (!busy_n_out) begin
      data_out <= ~data_out;
      cnt      <= cnt - 16'h0001;
      if (cnt == 16'h0001) begin
        busy_n_out <= 1'b1;
        data_out   <= value_in;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for the transfer control top
// Assumes: 40 MHz clock, inputs driven on the falling edge
// Notes:   expected host words queue up at store time
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst, store, hit_a, hit_b, req_d;
  logic [15:0] code, val_a, val_b, cyc_a, cyc_b;
  logic        peak_a_n, busy_a_n, peak_b_n, busy_b_n;
  logic [15:0] data_a, data_b, host_data;
  logic        start_a, rearm_a, start_b, rearm_b, host_req, timeout, overrun;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  int          failures, cmp_count, words_seen;

  always #12.5 clk = ~clk;

  dpatc_conv_model u_chan_a (.clk_in(clk), .hit_in(hit_a), .start_in(start_a), .rearm_in(rearm_a),
    .value_in(val_a), .conv_cycles_in(cyc_a), .peak_n_out(peak_a_n), .busy_n_out(busy_a_n), .data_out(data_a));
  dpatc_conv_model u_chan_b (.clk_in(clk), .hit_in(hit_b), .start_in(start_b), .rearm_in(rearm_b),
    .value_in(val_b), .conv_cycles_in(cyc_b), .peak_n_out(peak_b_n), .busy_n_out(busy_b_n), .data_out(data_b));
  dpatc_top u_dut (.SYS_CLK_IN(clk), .RST_IN(rst),
    .PEAK_CAPTURED_A_N_IN(peak_a_n), .CONV_BUSY_A_N_IN(busy_a_n), .CONV_DATA_A_IN(data_a),
    .CONV_START_A_OUT(start_a), .PEAK_REARM_A_OUT(rearm_a),
    .PEAK_CAPTURED_B_N_IN(peak_b_n), .CONV_BUSY_B_N_IN(busy_b_n), .CONV_DATA_B_IN(data_b),
    .CONV_START_B_OUT(start_b), .PEAK_REARM_B_OUT(rearm_b), .STORE_IN(store), .EVENT_CODE_IN(code),
    .HOST_DATA_OUT(host_data), .HOST_REQ_OUT(host_req), .CONV_TIMEOUT_OUT(timeout), .XFER_OVERRUN_OUT(overrun));

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // each request pulse takes the oldest expected word
  always @(negedge clk) begin
    req_d <= host_req;
    if (!rst && host_req === 1'b1 && req_d !== 1'b1) begin
      words_seen++;
      if (exp_q.size() == 0)
        check_word("unrequested host word", 16'hxxxx, host_data);
      else
        check_word("host word", exp_q.pop_front(), host_data);
    end
  end

  task automatic wait_rearm(input logic a, input logic b);
    int k;
    k = 0;
    while (((a && !peak_a_n) || (b && !peak_b_n)) && k < 2000) begin
      tick(1);
      k++;
    end
    check_bit("channel rearmed", 1'b1, 1'(k < 2000));
  endtask

  task automatic store_word(input logic [15:0] c);
    code = c;
    store = 1'b1;
    exp_q.push_back(val_a);
    exp_q.push_back(val_b);
    exp_q.push_back(c);
    tick(3);
    store = 1'b0;
  endtask

  // budget counts from both channels done and the store seen
  task automatic wait_words(input int target);
    int k;
    k = 0;
    while (words_seen < target && k < dpatc_pkg::XFER_MAX_CYCLES) begin
      tick(1);
      k++;
    end
  endtask

  task automatic one_event(input logic store_first, input logic no_event, input logic b_first);
    logic [15:0] c;
    int          t;
    seed = lfsr(seed);
    val_a = seed[15:0];
    cyc_a = 16'h0064 + {7'h00, seed[24:16]};
    seed = lfsr(seed);
    val_b = seed[15:0];
    cyc_b = 16'h0064 + {7'h00, seed[24:16]};
    seed = lfsr(seed);
    c = no_event ? dpatc_pkg::NO_EVENT_CODE : seed[15:0];
    t = words_seen + 3;
    if (store_first)
      store_word(c);
    if (b_first) begin
      hit_b = 1'b1;
      tick(1);
      hit_b = 1'b0;
      tick(20);
    end
    hit_a = 1'b1;
    hit_b = !b_first;
    tick(1);
    hit_a = 1'b0;
    hit_b = 1'b0;
    wait_rearm(1'b1, 1'b1);
    if (!store_first)
      store_word(c);
    wait_words(t);
    check_bit("three words in budget", 1'b1, 1'(words_seen >= t));
    check_bit("timeout flag clear", 1'b0, timeout);
    check_bit("overrun flag clear", 1'b0, overrun);
    $display("test done: store_first=%0b no_event=%0b b_first=%0b", store_first, no_event, b_first);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    store = 1'b0;
    hit_a = 1'b0;
    hit_b = 1'b0;
    req_d = 1'b0;
    code = 16'h0000;
    val_a = 16'h0000;
    val_b = 16'h0000;
    cyc_a = 16'h0064;
    cyc_b = 16'h0064;
    seed = 32'haf41_882d;
    failures = 0;
    cmp_count = 0;
    words_seen = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check_bit("request idle after reset", 1'b0, host_req);
    check_word("host word after reset", 16'h0000, host_data);
    $display("test done: reset");
    one_event(1'b0, 1'b0, 1'b0);
    one_event(1'b0, 1'b1, 1'b1);
    one_event(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      one_event(1'b0, 1'(i == 1), 1'(i == 2));
    end
    // stalled converter: rearm must still come and the flag must rise
    cyc_a = 16'h07d0;
    hit_a = 1'b1;
    tick(1);
    hit_a = 1'b0;
    wait_rearm(1'b1, 1'b0);
    tick(2);
    check_bit("conversion timeout flag", 1'b1, timeout);
    check_word("no stray host words", 16'h0012, 16'(words_seen));
    $display("test done: stalled conversion");
    results;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("[ERR] watchdog expected finish seen hang");
    results;
  end
endmodule
`default_nettype wire
